// *** onchip_memory_pkg.sv ***
package onchip_memory_pkg;

	// Register byte offsets on the APB slave
	localparam logic [7:0] MODULE_STOP_OFFSET   = 8'h00;
	localparam logic [7:0] SYSTEM_CTRL_OFFSET   = 8'h04;
	localparam logic [7:0] FLASH_CTRL_OFFSET    = 8'h08;
	localparam logic [7:0] FLASH_ERROR_OFFSET   = 8'h0c;
	localparam logic [7:0] RAM_EMULATION_OFFSET = 8'h10;

	// Module stop control fields
	localparam int ROM_STOP_BIT = 0;
	localparam int RAM_STOP_BIT = 1;
	localparam logic [1:0] MODULE_STOP_RESET = 2'h0;

	// System control fields
	localparam int RAM_ENABLE_BIT = 0;
	localparam logic RAM_ENABLE_RESET = 1'b1;

	// Flash control register one fields
	localparam int REWRITE_ENABLE_BIT = 0;
	localparam int ERASE_SETUP_BIT    = 1;
	localparam int PROGRAM_SETUP_BIT  = 2;
	localparam int ERASE_VERIFY_BIT   = 3;
	localparam int PROGRAM_VERIFY_BIT = 4;
	localparam int PROGRAM_BIT        = 5;
	localparam int ERASE_BIT          = 6;
	localparam logic [6:0] FLASH_CTRL_RESET = 7'h00;

	// RAM emulation register fields
	localparam int EMU_SELECT_BIT = 8;
	localparam int EMU_AREA_LSB   = 0;
	localparam int EMU_AREA_W     = 4;
	localparam logic [4:0] RAM_EMULATION_RESET = 5'h00;

	// Memory map
	localparam logic [31:0] ROM_BASE     = 32'h00000000;
	localparam logic [31:0] ROM_LAST     = 32'h0003ffff;
	localparam logic [18:0] RAM_TAG      = 19'h7ffff;
	localparam int          ROM_WORDS    = 65536;
	localparam int          RAM_WORDS    = 2048;
	localparam int          EMU_BLOCK_AW = 12;

	// Operating modes that map the ROM
	localparam logic [3:0] MODE_ROM_A = 4'h2;
	localparam logic [3:0] MODE_ROM_B = 4'h3;

	// Settle time after clearing rewrite enable, kept by software
	localparam int REWRITE_SETTLE_US = 100;
	localparam int CLOCK_MHZ         = 100;
	localparam int REWRITE_SETTLE_CYCLES = REWRITE_SETTLE_US * CLOCK_MHZ;

	// Access widths
	typedef enum logic [1:0]
	{
		SIZE_BYTE,
		SIZE_HALF,
		SIZE_WORD
	} access_size_t;

	// Shared memory bus request
	typedef struct packed
	{
		logic         sel;
		logic         write;
		access_size_t size;
		logic [31:0]  addr;
		logic [31:0]  wdata;
	} mem_req_t;

endpackage

// *** onchip_word_memory.sv ***
`timescale 1ns/1ps
module onchip_word_memory
	import onchip_memory_pkg::*;
#(
	parameter int DEPTH = 2048,
	parameter int AW    = 11
)
(
	input  wire logic          sys_clk,
	input  wire logic          enable,
	input  wire logic [3:0]    byteWrite,
	input  wire logic [AW-1:0] wordAddr,
	input  wire logic [31:0]   wdata,
	output logic      [31:0]   rdata
);

	// Storage array, never reset so contents survive every reset
	logic [31:0] mem [DEPTH];

	// Byte lanes written independently
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++)
		begin : gLane
			always_ff @(posedge sys_clk)
			begin
				if (enable && byteWrite[lane])
				begin
					mem[wordAddr][lane*8 +: 8] <= wdata[lane*8 +: 8];
				end
			end
		end
	endgenerate

	// Registered read port
	always_ff @(posedge sys_clk)
	begin
		if (enable)
		begin
			rdata <= mem[wordAddr];
		end
	end

endmodule

// *** onchip_memory_access_control.sv ***
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module onchip_memory_access_control
	import onchip_memory_pkg::*;
#(
	parameter bit          HAS_FLASH  = 1'b1,
	parameter logic [31:0] UNDEF_DATA = 32'h00000000
)
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire mem_req_t    memReq,
	output logic      [31:0] memRdata,
	output logic             memReady,
	input  wire logic [3:0]  modeSelectPins,
	input  wire logic        flashWriteProtectPin,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             flashErrorFlag
);

	// Read data source of the access in flight
	typedef enum
	{
		TGT_NONE,
		TGT_ROM,
		TGT_RAM
	} target_t;

	// Software visible state and the read data source
	logic [1:0]              moduleStop_reg;         // Stop bits for ROM and RAM
	logic                    ramEnable_reg;          // RAM enable bit
	logic [6:0]              flashCtrl_reg;          // Flash control register one
	logic [6:0]              flashCtrl_next;         // Its next value
	logic                    flashError_reg;         // Sticky flash error flag
	logic                    emuSelect_reg;          // RAM emulation select
	logic [EMU_AREA_W-1:0]   emuArea_reg;            // Emulated flash block
	target_t                 target_reg;             // Source for read data

	// Decoded access
	logic                    romMapped;              // Mode pins map the ROM
	logic                    inRom;                  // Address in ROM range
	logic                    inRam;                  // Address in RAM range
	logic                    inEmu;                  // Address in emulated block
	logic                    romAccess;              // Live flash array access
	logic                    ramAccess;              // Live RAM array access
	logic                    emuAccess;              // Overlay access to RAM
	logic                    programActive;          // Program or erase running
	logic                    flashReadFault;         // Read during program/erase
	logic                    flashProgramWrite;      // Write that programs flash
	logic [3:0]              laneMask;               // Byte lanes of the access
	logic [3:0]              ramWrite;               // RAM lane writes
	logic [3:0]              romWrite;               // Flash lane writes
	logic [10:0]             ramIndex;               // RAM word address
	logic [15:0]             romIndex;               // ROM word address
	logic [31:0]             romRdata;               // ROM array read data
	logic [31:0]             ramRdata;               // RAM array read data

	// APB decode
	logic                    apbWrite;               // Write in access phase
	logic                    apbRead;                // Read in setup phase
	logic                    addrMapped;             // Offset names a register
	logic                    flashRegHit;            // Offset is a flash register

	// Flash array, also the ROM image
	onchip_word_memory #(
		.DEPTH    (ROM_WORDS),
		.AW       (16)
	) romArray (
		.sys_clk  (sys_clk),
		.enable   (romAccess),
		.byteWrite(romWrite),
		.wordAddr (romIndex),
		.wdata    (memReq.wdata),
		.rdata    (romRdata)
	);

	// Static RAM, no reset reaches the array
	onchip_word_memory #(
		.DEPTH    (RAM_WORDS),
		.AW       (11)
	) ramArray (
		.sys_clk  (sys_clk),
		.enable   (ramAccess || emuAccess),
		.byteWrite(ramWrite),
		.wordAddr (ramIndex),
		.wdata    (memReq.wdata),
		.rdata    (ramRdata)
	);

	// Address decode of the shared memory bus
	always_comb
	begin
		romMapped = (modeSelectPins == MODE_ROM_A) || (modeSelectPins == MODE_ROM_B);
		inRom     = (memReq.addr[31:18] == ROM_BASE[31:18]);
		inRam     = (memReq.addr[31:13] == RAM_TAG);
		inEmu     = inRom && (memReq.addr[17:EMU_BLOCK_AW] == {2'b00, emuArea_reg});
	end

	// Which array an access reaches
	always_comb
	begin
		// Overlay wins over flash, whatever rewrite enable says
		emuAccess = memReq.sel && HAS_FLASH && emuSelect_reg && inEmu && romMapped
			&& !moduleStop_reg[RAM_STOP_BIT] && ramEnable_reg;
		// Flash reached only when mapped and not stopped
		romAccess = memReq.sel && inRom && romMapped && !emuAccess
			&& !moduleStop_reg[ROM_STOP_BIT];
		// RAM needs enable bit and no module stop
		ramAccess = memReq.sel && inRam && ramEnable_reg
			&& !moduleStop_reg[RAM_STOP_BIT];
	end

	// Byte lanes from size and low address bits
	always_comb
	begin
		unique case (memReq.size)
			SIZE_BYTE: laneMask = 4'h1 << memReq.addr[1:0];
			SIZE_HALF: laneMask = memReq.addr[1] ? 4'hc : 4'h3;
			SIZE_WORD: laneMask = 4'hf;
			default:   laneMask = 4'h0;                                           // Illegal size
		endcase
	end

	// Program or erase in progress, and its faults
	always_comb
	begin
		programActive = flashCtrl_reg[PROGRAM_BIT] || flashCtrl_reg[ERASE_BIT];
		// Any flash read while the array is busy is a fault
		flashReadFault = HAS_FLASH && romAccess && !memReq.write && programActive;
		// Programming writes only with rewrite enabled and no protection
		flashProgramWrite = HAS_FLASH && romAccess && memReq.write
			&& flashCtrl_reg[REWRITE_ENABLE_BIT] && flashCtrl_reg[PROGRAM_BIT]
			&& !flashError_reg && !emuSelect_reg && !flashWriteProtectPin;
	end

	// Lane writes and word indexes
	always_comb
	begin
		// Disabled targets drop the write entirely
		ramWrite = (memReq.write && (ramAccess || emuAccess)) ? laneMask : 4'h0;
		romWrite = flashProgramWrite ? laneMask : 4'h0;
		ramIndex = emuAccess ? {1'b0, memReq.addr[11:2]} : memReq.addr[12:2];
		romIndex = memReq.addr[17:2];
	end

	// Remember the source of the data answer
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			target_reg <= TGT_NONE;
		end
		else if (memReq.sel && !memReq.write && (ramAccess || emuAccess))
		begin
			target_reg <= TGT_RAM;
		end
		else if (memReq.sel && !memReq.write && romAccess && !programActive)
		begin
			target_reg <= TGT_ROM;
		end
		else
		begin
			// Disabled, unmapped or faulting reads give undefined data
			target_reg <= TGT_NONE;
		end
	end

	// Memory read data, one cycle after the request
	always_comb
	begin
		memRdata = UNDEF_DATA;
		unique case (target_reg)
			TGT_ROM:  memRdata = romRdata;
			TGT_RAM:  memRdata = ramRdata;
			TGT_NONE: memRdata = UNDEF_DATA;
		endcase
	end

	// Never stalls the shared bus
	assign memReady = 1'b1;

	// APB setup and access phase decode
	always_comb
	begin
		apbWrite    = psel && penable && pwrite;
		apbRead     = psel && !penable && !pwrite;
		flashRegHit = (paddr == FLASH_CTRL_OFFSET) || (paddr == FLASH_ERROR_OFFSET)
			|| (paddr == RAM_EMULATION_OFFSET);
		addrMapped  = (paddr == MODULE_STOP_OFFSET) || (paddr == SYSTEM_CTRL_OFFSET)
			|| flashRegHit;
	end

	// Module stop control register
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			moduleStop_reg <= MODULE_STOP_RESET;
		end
		else if (apbWrite && (paddr == MODULE_STOP_OFFSET))
		begin
			moduleStop_reg <= pwdata[1:0];
		end
	end

	// System control register
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			ramEnable_reg <= RAM_ENABLE_RESET;
		end
		else if (apbWrite && (paddr == SYSTEM_CTRL_OFFSET))
		begin
			ramEnable_reg <= pwdata[RAM_ENABLE_BIT];
		end
	end

	// Next value of flash control register one
	always_comb
	begin
		flashCtrl_next = flashCtrl_reg;
		if (apbWrite && (paddr == FLASH_CTRL_OFFSET) && HAS_FLASH)
		begin
			flashCtrl_next = pwdata[6:0];
			// Without rewrite enable program and erase do not start
			if (!pwdata[REWRITE_ENABLE_BIT])
			begin
				flashCtrl_next[PROGRAM_BIT] = 1'b0;
				flashCtrl_next[ERASE_BIT]   = 1'b0;
			end
		end
		// Emulation and error protection hold off program and erase
		if (emuSelect_reg || flashError_reg || flashReadFault)
		begin
			flashCtrl_next[PROGRAM_BIT] = 1'b0;
			flashCtrl_next[ERASE_BIT]   = 1'b0;
		end
		// Write protect pin high forces the whole register clear
		if (flashWriteProtectPin)
		begin
			flashCtrl_next = FLASH_CTRL_RESET;
		end
	end

	// Flash control register one
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			flashCtrl_reg <= FLASH_CTRL_RESET;
		end
		else
		begin
			flashCtrl_reg <= flashCtrl_next;
		end
	end

	// Sticky flash error, cleared by reset only
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			flashError_reg <= 1'b0;
		end
		else if (flashReadFault)
		begin
			flashError_reg <= 1'b1;
		end
	end

	// RAM emulation register
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			emuSelect_reg <= RAM_EMULATION_RESET[4];
			emuArea_reg   <= RAM_EMULATION_RESET[3:0];
		end
		else if (apbWrite && (paddr == RAM_EMULATION_OFFSET) && HAS_FLASH)
		begin
			emuSelect_reg <= pwdata[EMU_SELECT_BIT];
			emuArea_reg   <= pwdata[EMU_AREA_LSB +: EMU_AREA_W];
		end
	end

	// APB read data, loaded at the setup edge so it stands in the access phase
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			prdata <= 32'h00000000;
		end
		else if (apbRead)
		begin
			prdata <= 32'h00000000;
			if (!HAS_FLASH && flashRegHit)
			begin
				// No flash behind these offsets in the ROM-only build
				prdata <= UNDEF_DATA;
			end
			else if (paddr == MODULE_STOP_OFFSET)
			begin
				prdata[1:0] <= moduleStop_reg;
			end
			else if (paddr == SYSTEM_CTRL_OFFSET)
			begin
				prdata[RAM_ENABLE_BIT] <= ramEnable_reg;
			end
			else if (paddr == FLASH_CTRL_OFFSET)
			begin
				prdata[6:0] <= flashCtrl_reg;
			end
			else if (paddr == FLASH_ERROR_OFFSET)
			begin
				prdata[0] <= flashError_reg;
			end
			else if (paddr == RAM_EMULATION_OFFSET)
			begin
				prdata[EMU_SELECT_BIT] <= emuSelect_reg;
				prdata[EMU_AREA_LSB +: EMU_AREA_W] <= emuArea_reg;
			end
		end
	end

	// Zero wait state slave, error on unmapped offsets
	always_comb
	begin
		pready  = 1'b1;
		pslverr = psel && penable && !addrMapped;
	end

	// Error flag also brought out as a level
	assign flashErrorFlag = flashError_reg;

endmodule

// *** onchip_memory_assertions.sv ***
`timescale 1ns/1ps
module onchip_memory_assertions
	import onchip_memory_pkg::*;
#(
	parameter logic [31:0] UNDEF_DATA = 32'h00000000
)
(
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire mem_req_t    memReq,
	input wire logic [31:0] memRdata,
	input wire logic        memReady,
	input wire logic [3:0]  modeSelectPins,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        flashErrorFlag
);
	logic [1:0] stopReg;  // Shadow of module stop
	logic       ramOnReg; // Shadow of RAM enable
	logic       emuReg;   // Shadow of emulation select
	wire        rd     = memReq.sel && !memReq.write;
	wire        romHit = memReq.addr <= ROM_LAST;
	wire        ramHit = &memReq.addr[31:13];
	wire        modeOk = modeSelectPins inside {MODE_ROM_A, MODE_ROM_B};

	// Follow control writes on APB
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			stopReg  <= MODULE_STOP_RESET;
			ramOnReg <= RAM_ENABLE_RESET;
			emuReg   <= 1'b0;
		end
		else if (psel && penable && pwrite)
		begin
			if (paddr == MODULE_STOP_OFFSET)
				stopReg <= pwdata[1:0];
			if (paddr == SYSTEM_CTRL_OFFSET)
				ramOnReg <= pwdata[RAM_ENABLE_BIT];
			if (paddr == RAM_EMULATION_OFFSET)
				emuReg <= pwdata[EMU_SELECT_BIT];
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_no_wait_state: assert property (memReady && pready)
		else $error("Bus stalled");
	a_rom_mode_off: assert property (rd && romHit && !modeOk |=> memRdata == UNDEF_DATA)
		else $error("ROM answered in unmapped mode");
	a_rom_stopped: assert property (
		rd && romHit && stopReg[ROM_STOP_BIT] && !emuReg |=> memRdata == UNDEF_DATA)
		else $error("Stopped ROM answered");
	a_ram_disabled: assert property (
		rd && ramHit && (stopReg[RAM_STOP_BIT] || !ramOnReg) |=> memRdata == UNDEF_DATA)
		else $error("Disabled RAM answered");
	a_map_hole: assert property (rd && !romHit && !ramHit |=> memRdata == UNDEF_DATA)
		else $error("Unmapped address answered");
	a_error_sticky: assert property (flashErrorFlag |=> flashErrorFlag)
		else $error("Error flag dropped");
	a_error_cause: assert property (
		$rose(flashErrorFlag) |-> $past(rd && romHit) && memRdata == UNDEF_DATA)
		else $error("Error flag without flash read");
	a_slverr_map: assert property (psel && penable
		|-> pslverr == (paddr[1:0] != 2'h0 || paddr > RAM_EMULATION_OFFSET))
		else $error("Slave error mismatch");
	a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("Read data changed without read");
endmodule

bind onchip_memory_access_control onchip_memory_assertions #(.UNDEF_DATA(UNDEF_DATA)) chk
(
	.sys_clk(sys_clk), .nrst(nrst), .memReq(memReq), .memRdata(memRdata),
	.memReady(memReady), .modeSelectPins(modeSelectPins), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .flashErrorFlag(flashErrorFlag)
);

// *** mem_bus_master.sv ***
`timescale 1ns/1ps
module mem_bus_master
	import onchip_memory_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic [31:0] memRdata,
	output mem_req_t         memReq
);
	initial
		memReq = '0;

	// One single-cycle request, then read data a cycle later
	// Callers read flash while rewriting only in verify mode, and once during erase
	task automatic xfer(input logic wr, input access_size_t sz, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		memReq <= '{sel: 1'b1, write: wr, size: sz, addr: a, wdata: d};
		@(posedge sys_clk);
		// Released bus shows no stale value
		memReq <= '{sel: 1'b0, write: ~wr, size: sz, addr: ~a, wdata: ~d};
		@(negedge sys_clk);
		q = memRdata;
	endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import onchip_memory_pkg::*;
	localparam logic [31:0] UNDEF = 32'hbad0bad0; // Stand-in for undefined data
	localparam logic [31:0] RAM0  = 32'hffffe000; // RAM base
	logic        sys_clk;
	logic        nrst;
	mem_req_t    memReq;
	logic [31:0] memRdata;
	logic [3:0]  modeSelectPins;
	logic        flashWriteProtectPin;
	logic        psel, penable, pwrite, pready, pslverr, flashErrorFlag;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, a, w, r;
	logic [31:0] prdataRom; // Read data of the ROM-only build
	integer      seed = 32'h0037;
	int          fails = 0;
	int          num_checks = 0;
	logic [31:0] shadow [int]; // Expected RAM words

	// Free-running clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	onchip_memory_access_control #(.UNDEF_DATA(UNDEF)) uut
	(
		.sys_clk(sys_clk), .nrst(nrst), .memReq(memReq), .memRdata(memRdata),
		.memReady(), .modeSelectPins(modeSelectPins),
		.flashWriteProtectPin(flashWriteProtectPin), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flashErrorFlag(flashErrorFlag)
	);
	// ROM-only build on the same buses, only its register read data is compared
	onchip_memory_access_control #(.HAS_FLASH(1'b0), .UNDEF_DATA(UNDEF)) uutRom
	(
		.sys_clk(sys_clk), .nrst(nrst), .memReq(memReq), .memRdata(), .memReady(),
		.modeSelectPins(modeSelectPins), .flashWriteProtectPin(flashWriteProtectPin),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdataRom), .pready(), .pslverr(), .flashErrorFlag()
	);
	mem_bus_master master (.sys_clk(sys_clk), .memRdata(memRdata), .memReq(memReq));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// APB transfer, holds request until pready
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] rq, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Access phase lasts until pready is seen high at a rising edge
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		// Answer taken at that same edge, then the request is released
		e = pslverr;
		rq = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rw(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, ad, d, x, e);
	endtask

	task automatic rchk(input logic [7:0] ad, input logic [31:0] exp, input logic eexp);
		logic [31:0] x;
		logic e;
		apb(1'b0, ad, 32'h0, x, e);
		check("register", x, exp);
		check("slave error", {31'h0, e}, {31'h0, eexp});
	endtask

	task automatic mchk(input logic [31:0] ad, input logic [31:0] exp);
		master.xfer(1'b0, SIZE_WORD, ad, 32'h0, q);
		check("memory read", q, exp);
	endtask

	task automatic mw(input access_size_t s, input logic [31:0] ad, input logic [31:0] d);
		master.xfer(1'b1, s, ad, d, q);
	endtask

	task automatic rst;
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
	endtask

	// Expected word after a lane write
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input access_size_t s, input logic [1:0] l);
		logic [3:0] m;
		m = s == SIZE_WORD ? 4'hf : s == SIZE_HALF ? (l[1] ? 4'hc : 4'h3) : 4'h1 << l;
		for (int b = 0; b < 4; b++)
			if (m[b])
				o[8*b+:8] = n[8*b+:8];
		return o;
	endfunction

	// Watchdog, also the guard against runaway stimulus
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		wrap_up;
	end

	initial
	begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		modeSelectPins = MODE_ROM_A;
		flashWriteProtectPin = 1'b1;
		rst;
		flashWriteProtectPin <= 1'b0; // Bits clear, no interrupts
		// Reset values and an unmapped offset
		for (int i = 0; i < 6; i++)
		begin
			rchk(8'(4 * i), i == 1, i == 5);
			check("rom-only reg", prdataRom, (i >= 2 && i <= 4) ? UNDEF : 32'(i == 1));
		end
		$display("Test registers done");
		// Random lane writes into RAM
		for (int i = 0; i < 16; i++)
		begin
			r = $random(seed);
			a = RAM0 + {r[12:2], 2'h0};
			w = $random(seed);
			mw(SIZE_WORD, a, w);
			shadow[i] = w;
			w = $random(seed);
			mw(access_size_t'(r[14:13] % 2'd3), a + r[16:15], w);
			mchk(a, merge(shadow[i], w, access_size_t'(r[14:13] % 2'd3), r[16:15]));
		end
		$display("Test lanes done");
		// Stopped or disabled RAM drops writes
		for (int k = 0; k < 2; k++)
		begin
			mw(SIZE_WORD, RAM0 + 32'h100, 32'h1111_2222);
			rw(k ? SYSTEM_CTRL_OFFSET : MODULE_STOP_OFFSET, k ? 32'h0 : 32'h2);
			mw(SIZE_WORD, RAM0 + 32'h100, 32'h3333_4444);
			mchk(RAM0 + 32'h100, UNDEF);
			rw(MODULE_STOP_OFFSET, 32'h0);
			rw(SYSTEM_CTRL_OFFSET, 32'h1);
			mchk(RAM0 + 32'h100, 32'h1111_2222);
		end
		$display("Test disable done");
		// Emulation overlay follows mode pins
		rw(RAM_EMULATION_OFFSET, 32'h103);
		mw(SIZE_WORD, RAM0 + 32'h10, 32'h0badcafe);
		for (int m = 0; m < 16; m++)
		begin
			@(posedge sys_clk);
			modeSelectPins <= 4'(m);
			mchk(32'h3010, m inside {2, 3} ? 32'h0badcafe : UNDEF);
		end
		@(posedge sys_clk);
		modeSelectPins <= MODE_ROM_B;
		for (int k = 0; k < 2; k++)
		begin
			rw(FLASH_CTRL_OFFSET, k);
			w = $random(seed);
			mw(SIZE_WORD, 32'h3020, w);
			mchk(RAM0 + 32'h20, w);
		end
		rw(FLASH_CTRL_OFFSET, 32'h21);
		rchk(FLASH_CTRL_OFFSET, 32'h01, 1'b0);
		rw(RAM_EMULATION_OFFSET, 32'h0);
		$display("Test emulation done");
		// Program one flash word, verify it, then a stopped ROM
		rw(FLASH_CTRL_OFFSET, 32'h21);
		w = $random(seed);
		mw(SIZE_WORD, 32'h400, w); // One program of an erased unit
		rw(FLASH_CTRL_OFFSET, 32'h11);
		mchk(32'h400, w); // Verify read
		rw(MODULE_STOP_OFFSET, 32'h1);
		mchk(32'h400, UNDEF);
		rw(MODULE_STOP_OFFSET, 32'h0);
		// Flash read during erase
		rw(FLASH_CTRL_OFFSET, 32'h41);
		rchk(FLASH_CTRL_OFFSET, 32'h41, 1'b0);
		mchk(32'h200, UNDEF);
		check("error flag", {31'h0, flashErrorFlag}, 32'h1);
		rchk(FLASH_CTRL_OFFSET, 32'h01, 1'b0);
		rw(FLASH_CTRL_OFFSET, 32'h41);
		rchk(FLASH_CTRL_OFFSET, 32'h01, 1'b0);
		rchk(FLASH_ERROR_OFFSET, 32'h1, 1'b0);
		@(posedge sys_clk);
		flashWriteProtectPin <= 1'b1;
		repeat (2) @(posedge sys_clk);
		flashWriteProtectPin <= 1'b0; // Released with control bits clear
		rchk(FLASH_CTRL_OFFSET, 32'h0, 1'b0);
		$display("Test error done");
		// RAM survives reset, error flag does not
		mw(SIZE_WORD, RAM0 + 32'h1ffc, 32'h600d_f00d);
		// Rewrite enable is clear, settle before resetting the flash
		repeat (REWRITE_SETTLE_CYCLES) @(posedge sys_clk);
		rst;
		check("error flag", {31'h0, flashErrorFlag}, 32'h0);
		mchk(RAM0 + 32'h1ffc, 32'h600d_f00d);
		$display("Test retention done");
		wrap_up;
	end
endmodule
